// ---- shared/pcs_pkg.sv ----
// shared constants, types and helpers of the power state controller
package pcs_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int POWER_UP_RESET_INTERVAL_US = 10;
    // longest interval: round down, never below one cycle
    localparam int POR_RAW = (POWER_UP_RESET_INTERVAL_US * 1000)
                             / CLK_PERIOD_NS;
    localparam int POR_CYCLES = (POR_RAW < 1) ? 1 : POR_RAW;
    localparam int POR_CNT_W = $clog2(POR_CYCLES + 1);
    localparam int SLOW_EDGE_DELAY_ADDER_NS = 3;
    // extra delay of slow outputs: round up, at least one cycle
    localparam int SLOW_RAW = (SLOW_EDGE_DELAY_ADDER_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
    localparam int SLOW_CYCLES = (SLOW_RAW < 1) ? 1 : SLOW_RAW;
    localparam int NUM_CELLS = 32;
    localparam int SIGNATURE_BITS = 160;
    localparam int SIG_WORDS = SIGNATURE_BITS / 32;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_SLEW = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_PRELOAD_MASK = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_PRELOAD_DATA = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_CELL_STATE = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_SIG_BASE = 8'h20;
    localparam int CTRL_SLEEP_EN_BIT = 0;
    localparam int CTRL_FUSE_BIT = 1;
    localparam int STATUS_POR_BIT = 0;
    localparam int STATUS_ASLEEP_BIT = 1;
    localparam int STATUS_LOCK_BIT = 2;
    localparam int STATUS_REFUSED_BIT = 3;
    localparam int STATUS_FEATURE_BIT = 4;
    localparam logic [31:0] SLEW_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PCS_POR_CLEAR = 2'b00,
        PCS_RUN = 2'b01,
        PCS_ASLEEP = 2'b10
    } pcs_state_t;

    // byte-lane merge of a bus write into an old word
    function automatic logic [31:0] pcs_merge(input logic [31:0] oldVal,
                                              input logic [31:0] newVal,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = oldVal;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = newVal[b*8 +: 8];
            end
        end
        return res;
    endfunction
endpackage

// ---- shared/pcs_out_if.sv ----
// cell outputs, enables and slew settings toward the output stage
interface pcs_out_if #(parameter int WIDTH = 32);
    logic [WIDTH-1:0] data;
    logic [WIDTH-1:0] oe;
    logic [WIDTH-1:0] fast;
    modport src (output data, output oe, output fast);
    modport dst (input data, input oe, input fast);
endinterface

// ---- logic/pcs_pin_sync.sv ----
// two-stage synchroniser for pin inputs
module pcs_pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] metaReg;

    // first stage is read by the second stage only
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            metaReg <= '0;
            syncOut <= '0;
        end else begin
            metaReg <= asyncIn;
            syncOut <= metaReg;
        end
    end
endmodule // pcs_pin_sync

// ---- logic/pcs_slew_stage.sv ----
// output stage with per-output fast or slow edge timing
module pcs_slew_stage #(
    parameter int WIDTH = 32
) (
    input wire logic clk_sys,
    input wire logic reset,
    pcs_out_if.dst cells,
    output logic [WIDTH-1:0] pinOut,
    output logic [WIDTH-1:0] pinOe
);
    import pcs_pkg::*;

    logic [2*WIDTH-1:0] pipeReg [SLOW_CYCLES];
    logic [2*WIDTH-1:0] slowTap;

    // slow outputs run through a short delay line
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pipeReg[0] <= '0;
        end else begin
            pipeReg[0] <= {cells.oe, cells.data};
        end
    end

    genvar k;
    generate
        for (k = 1; k < SLOW_CYCLES; k++) begin : g_pipe
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    pipeReg[k] <= '0;
                end else begin
                    pipeReg[k] <= pipeReg[k-1];
                end
            end
        end
    endgenerate

    assign slowTap = pipeReg[SLOW_CYCLES-1];

    // hi-z outputs come up disabled; fast picks the direct path
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pinOut <= '0;
            pinOe <= '0;
        end else begin
            pinOut <= (cells.data & cells.fast)
                      | (slowTap[WIDTH-1:0] & ~cells.fast);
            pinOe <= (cells.oe & cells.fast)
                     | (slowTap[2*WIDTH-1:WIDTH] & ~cells.fast);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    chk_fast_path: assert property (
        (cells.fast == '1) |=> pinOut == $past(cells.data))
        else $error("fast output not one cycle behind its cell");
    chk_slow_lag: assert property (
        (cells.fast == '0)[*2] ##0 !$past(reset, 2)
        |-> pinOut == $past(cells.data, SLOW_CYCLES + 1))
        else $error("slow output lacks its extra delay");
endmodule // pcs_slew_stage

// ---- logic/pcs_power_state_ctrl.sv ----
// power-up clear, pin sleep, preload, slew and lock for a cell array
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.

// Summary of operation
// - power-up clear forces every cell register to zero, outputs low
// - with the feature on, a high sleep pin enters power-down
// - power-down freezes cell registers and every output value
// - outputs disabled at power-down entry stay disabled throughout
// - power-down blocks all inputs except the sleep pin
// - input hold latches keep their last levels during power-down
// - with the feature on, the sleep pin never reaches the array
// - preload can force any chosen cell register to one or zero
// - per-output slew bit, default slow, slow adds output delay
// - once locked, verify and preload refused, signature still readable
// - lock acts at once on the write that sets it
module pcs_power_state_ctrl #(
    parameter int NUM_CELLS = pcs_pkg::NUM_CELLS,
    parameter bit SLEEP_FEATURE = 1'b1
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [pcs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pcs_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_CELLS-1:0] ioIn,
    input wire logic [NUM_CELLS-1:0] oeRequest,
    input wire logic sleepRequestPin,
    output logic [NUM_CELLS-1:0] ioOut,
    output logic [NUM_CELLS-1:0] ioOe,
    output logic [NUM_CELLS-1:0] keeperLevel,
    output logic sleepActive
);
    import pcs_pkg::*;

    localparam int SYNC_W = 2 * NUM_CELLS + 1;

    logic [SYNC_W-1:0] pinSync;
    logic [NUM_CELLS-1:0] ioSync;
    logic [NUM_CELLS-1:0] oeSync;
    logic sleepSync;
    pcs_state_t stateReg;
    pcs_state_t stateNext;
    logic [POR_CNT_W-1:0] porCountReg;
    logic [NUM_CELLS-1:0] macroReg;
    logic [NUM_CELLS-1:0] oeReg;
    logic [31:0] slewReg;
    logic [31:0] maskReg;
    logic [31:0] sigReg [SIG_WORDS];
    logic lockReg;
    logic sleepEnReg;
    logic refusedReg;
    logic sleepFeatureOn;
    logic porBusy;
    logic enterSleep;
    logic runTick;
    logic [NUM_CELLS-1:0] arrayIn;
    logic awHeldReg;
    logic wHeldReg;
    logic [ADDR_W-1:0] awAddrReg;
    logic [31:0] wDataReg;
    logic [3:0] wStrbReg;
    logic doWrite;
    logic arAccept;
    logic wrErr;
    logic rdErr;
    logic [31:0] rdData;
    logic preloadGo;
    logic [31:0] preloadWord;

    // signature window decode, shared by read and write paths
    function automatic logic isSig(input logic [ADDR_W-1:0] a);
        return (a >= ADDR_SIG_BASE)
               && (a < ADDR_SIG_BASE + ADDR_W'(4 * SIG_WORDS))
               && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [2:0] sigIdx(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - ADDR_SIG_BASE;
        return off[4:2];
    endfunction

    // every pin passes two flops before logic sees it
    pcs_pin_sync #(.WIDTH(SYNC_W)) uPinSync (
        .clk_sys(clk_sys),
        .reset(reset),
        .asyncIn({sleepRequestPin, oeRequest, ioIn}),
        .syncOut(pinSync)
    );

    assign ioSync = pinSync[NUM_CELLS-1:0];
    assign oeSync = pinSync[2*NUM_CELLS-1:NUM_CELLS];
    assign sleepSync = pinSync[2*NUM_CELLS];

    // build-time feature gates the run-time enable
    assign sleepFeatureOn = SLEEP_FEATURE && sleepEnReg;
    assign porBusy = (stateReg == PCS_POR_CLEAR);
    assign enterSleep = (stateReg == PCS_RUN) && sleepFeatureOn
                        && sleepSync;
    assign runTick = (stateReg == PCS_RUN) && !enterSleep;

    // sleep pin is an ordinary array input only with the feature off
    assign arrayIn = ioSync ^ {{(NUM_CELLS-1){1'b0}},
                               (!sleepFeatureOn && sleepSync)};

    // sequencer: clear interval, run, power-down
    always_comb begin
        stateNext = stateReg;
        unique case (stateReg)
            PCS_POR_CLEAR: begin
                if (porCountReg == POR_CNT_W'(POR_CYCLES - 1)) begin
                    stateNext = PCS_RUN;
                end
            end
            PCS_RUN: begin
                if (enterSleep) begin
                    stateNext = PCS_ASLEEP;
                end
            end
            PCS_ASLEEP: begin
                if (!sleepSync) begin
                    stateNext = PCS_RUN;
                end
            end
            default: begin
                stateNext = PCS_POR_CLEAR;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stateReg <= PCS_POR_CLEAR;
            sleepActive <= 1'b0;
        end else begin
            stateReg <= stateNext;
            sleepActive <= (stateNext == PCS_ASLEEP);
        end
    end

    // clear interval counter restarts with every reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            porCountReg <= '0;
        end else if (porBusy) begin
            porCountReg <= porCountReg + POR_CNT_W'(1);
        end
    end

    // preload is refused when locked or outside run
    assign preloadGo = doWrite && (awAddrReg == ADDR_PRELOAD_DATA)
                       && !lockReg && (stateReg == PCS_RUN);
    assign preloadWord = pcs_merge(32'(macroReg), wDataReg, wStrbReg);

    // cell registers: clear wins, then preload, then run; held asleep
    always_ff @(posedge clk_sys) begin
        if (reset || porBusy) begin
            macroReg <= '0;
        end else if (preloadGo) begin
            macroReg <= (macroReg & ~maskReg[NUM_CELLS-1:0])
                        | (preloadWord[NUM_CELLS-1:0]
                           & maskReg[NUM_CELLS-1:0]);
        end else if (runTick) begin
            macroReg <= arrayIn;
        end
    end

    // enables and hold latches only follow pins while running
    always_ff @(posedge clk_sys) begin
        if (reset || porBusy) begin
            oeReg <= '0;
        end else if (runTick) begin
            oeReg <= oeSync;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            keeperLevel <= '0;
        end else if (runTick) begin
            keeperLevel <= ioSync;
        end
    end

    // output stage owns the slew timing
    pcs_out_if #(.WIDTH(NUM_CELLS)) cellBus ();
    assign cellBus.data = macroReg;
    assign cellBus.oe = oeReg;
    assign cellBus.fast = slewReg[NUM_CELLS-1:0];

    pcs_slew_stage #(.WIDTH(NUM_CELLS)) uSlew (
        .clk_sys(clk_sys),
        .reset(reset),
        .cells(cellBus),
        .pinOut(ioOut),
        .pinOe(ioOe)
    );

    // axi write side: address and data taken in either order
    assign doWrite = awHeldReg && wHeldReg && !s_axi_bvalid;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            awHeldReg <= 1'b0;
            wHeldReg <= 1'b0;
            awAddrReg <= '0;
            wDataReg <= '0;
            wStrbReg <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeldReg <= 1'b1;
                awAddrReg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeldReg <= 1'b1;
                wDataReg <= s_axi_wdata;
                wStrbReg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrErr ? RESP_SLVERR : RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                awHeldReg <= 1'b0;
                wHeldReg <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // write decode; refused and unmapped writes answer slverr
    always_comb begin
        wrErr = 1'b0;
        unique case (1'b1)
            awAddrReg == ADDR_CTRL,
            awAddrReg == ADDR_STATUS,
            awAddrReg == ADDR_SLEW,
            awAddrReg == ADDR_PRELOAD_MASK: wrErr = 1'b0;
            awAddrReg == ADDR_PRELOAD_DATA: wrErr = !preloadGo;
            isSig(awAddrReg): wrErr = lockReg;
            default: wrErr = 1'b1;
        endcase
    end

    // configuration registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            slewReg <= SLEW_RESET;
            maskReg <= MASK_RESET;
            sleepEnReg <= SLEEP_FEATURE;
        end else if (doWrite) begin
            if (awAddrReg == ADDR_SLEW) begin
                slewReg <= pcs_merge(slewReg, wDataReg, wStrbReg);
            end
            if (awAddrReg == ADDR_PRELOAD_MASK) begin
                maskReg <= pcs_merge(maskReg, wDataReg, wStrbReg);
            end
            if (awAddrReg == ADDR_CTRL && wStrbReg[0]) begin
                sleepEnReg <= wDataReg[CTRL_SLEEP_EN_BIT];
            end
        end
    end

    // lock is sticky until reset and acts on the very write
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lockReg <= 1'b0;
        end else if (doWrite && awAddrReg == ADDR_CTRL && wStrbReg[0]
                     && wDataReg[CTRL_FUSE_BIT]) begin
            lockReg <= 1'b1;
        end
    end

    // signature words are writable only before the lock
    genvar s;
    generate
        for (s = 0; s < SIG_WORDS; s++) begin : g_sig
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    sigReg[s] <= '0;
                end else if (doWrite && isSig(awAddrReg) && !lockReg
                             && sigIdx(awAddrReg) == 3'(s)) begin
                    sigReg[s] <= pcs_merge(sigReg[s], wDataReg, wStrbReg);
                end
            end
        end
    endgenerate

    // refused flag: a new refusal beats a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            refusedReg <= 1'b0;
        end else if ((doWrite && awAddrReg == ADDR_PRELOAD_DATA && wrErr)
                     || (arAccept && rdErr)) begin
            refusedReg <= 1'b1;
        end else if (doWrite && awAddrReg == ADDR_STATUS && wStrbReg[0]
                     && wDataReg[STATUS_REFUSED_BIT]) begin
            refusedReg <= 1'b0;
        end
    end

    // read decode; verify is blanked once locked, signature is not
    always_comb begin
        rdData = '0;
        rdErr = 1'b0;
        unique case (1'b1)
            s_axi_araddr == ADDR_CTRL: begin
                rdData[CTRL_SLEEP_EN_BIT] = sleepEnReg;
                rdData[CTRL_FUSE_BIT] = lockReg;
            end
            s_axi_araddr == ADDR_STATUS: begin
                rdData[STATUS_POR_BIT] = porBusy;
                rdData[STATUS_ASLEEP_BIT] = (stateReg == PCS_ASLEEP);
                rdData[STATUS_LOCK_BIT] = lockReg;
                rdData[STATUS_REFUSED_BIT] = refusedReg;
                rdData[STATUS_FEATURE_BIT] = SLEEP_FEATURE;
            end
            s_axi_araddr == ADDR_SLEW: rdData = slewReg;
            s_axi_araddr == ADDR_PRELOAD_MASK: rdData = maskReg;
            s_axi_araddr == ADDR_CELL_STATE: begin
                rdErr = lockReg;
                rdData = lockReg ? '0 : 32'(macroReg);
            end
            isSig(s_axi_araddr): rdData = sigReg[sigIdx(s_axi_araddr)];
            default: rdErr = 1'b1;
        endcase
    end

    // axi read side: one read at a time, answer one cycle after address
    assign arAccept = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (arAccept) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdData;
            s_axi_rresp <= rdErr ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    chk_por_clear: assert property (
        porBusy ##2 1'b1 |-> ioOut == '0 || !$past(porBusy, 2))
        else $error("cell outputs not low during power-up clear");
    chk_por_length: assert property (
        $fell(porBusy) |-> $past(porCountReg) == POR_CNT_W'(POR_CYCLES - 1))
        else $error("power-up clear left early or late");
    chk_por_start: assert property (
        $fell(reset) |-> porBusy[*8])
        else $error("power-up clear not held after reset");
    chk_sleep_entry: assert property (
        enterSleep |=> sleepActive && stateReg == PCS_ASLEEP)
        else $error("sleep pin did not enter power-down");
    chk_sleep_off: assert property (
        (stateReg == PCS_RUN && !sleepFeatureOn) |=> stateReg != PCS_ASLEEP)
        else $error("power-down entered with feature off");
    chk_sleep_freeze: assert property (
        (stateReg == PCS_ASLEEP)[*3] |-> $stable(ioOut))
        else $error("outputs moved during power-down");
    chk_hiz_hold: assert property (
        (stateReg == PCS_ASLEEP)[*3] |-> $stable(ioOe))
        else $error("output enable moved during power-down");
    chk_input_block: assert property (
        (stateReg == PCS_ASLEEP)[*2] |-> $stable(macroReg) && $stable(oeReg))
        else $error("input reached state during power-down");
    chk_keeper_hold: assert property (
        (stateReg == PCS_ASLEEP)[*2] |-> $stable(keeperLevel))
        else $error("hold latch moved during power-down");
    chk_pin_isolate: assert property (
        sleepFeatureOn && runTick && !preloadGo |=> macroReg == $past(ioSync))
        else $error("sleep pin leaked into the array");
    chk_preload_set: assert property (
        preloadGo && wStrbReg == 4'hF
        |=> ((macroReg ^ $past(wDataReg[NUM_CELLS-1:0]))
             & $past(maskReg[NUM_CELLS-1:0])) == '0)
        else $error("preload did not force masked cells");
    chk_lock_refuse: assert property (
        doWrite && lockReg && awAddrReg == ADDR_PRELOAD_DATA
        |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
        else $error("preload accepted while locked");
    chk_lock_verify: assert property (
        arAccept && lockReg && s_axi_araddr == ADDR_CELL_STATE
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
        else $error("verify read allowed while locked");
    chk_lock_now: assert property (
        doWrite && awAddrReg == ADDR_CTRL && wStrbReg[0]
        && wDataReg[CTRL_FUSE_BIT] |=> lockReg [*3])
        else $error("lock not immediate or not sticky");

    cov_sleep_cycle: cover property (enterSleep ##[1:50] !sleepActive);
    cov_preload: cover property (preloadGo);
    cov_lock_refused: cover property (lockReg && refusedReg);
    cov_sig_read: cover property (arAccept && lockReg && isSig(s_axi_araddr));
endmodule // pcs_power_state_ctrl

// ---- verification/pcs_sys_model.sv ----
// system-side model driving the pins of the power state controller
module pcs_sys_model (
    input wire logic clk_sys,
    input wire logic [31:0] wantIo,
    input wire logic wantSleep,
    output logic [31:0] ioIn,
    output logic [31:0] oeRequest,
    output logic sleepRequestPin
);
    timeunit 1ns;
    timeprecision 1ps;
    // pins start low so nothing floats at time zero
    initial begin
        ioIn = 32'h0;
        oeRequest = 32'h0;
        sleepRequestPin = 1'b0;
    end
    // pins move only just after an edge, so setup always holds
    always @(posedge clk_sys) begin
        ioIn <= wantIo;
        oeRequest <= ~wantIo; // enables vary so hi-z bits exist
        sleepRequestPin <= wantSleep;
    end
endmodule // pcs_sys_model

// ---- verification/cpld_power_state_control_bench.sv ----
// self-checking bench of the power state controller
module cpld_power_state_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import pcs_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
    logic [31:0] wData = 32'h0, wantIo = 32'h0, pat, sig;
    logic awValid = 1'b0, wValid = 1'b0, arValid = 1'b0, wantSleep = 1'b0;
    logic [31:0] ioIn, oeReq, ioOut, oeOut, keep, rData;
    logic sleepPin, sleepAct, awRdy, wRdy, bValid, arRdy, rValid;
    logic [1:0] bResp, rResp;
    logic [33:0] rq[$];
    logic [1:0] wq[$];
    string rn[$];
    int seed = 2968;
    int n_fail = 0;
    int compares = 0;
    // free-running clock, stable across the clear interval
    always #4 clk_sys = ~clk_sys;
    pcs_sys_model sys_u (.clk_sys(clk_sys), .wantIo(wantIo),
        .wantSleep(wantSleep), .ioIn(ioIn), .oeRequest(oeReq),
        .sleepRequestPin(sleepPin));
    pcs_power_state_ctrl #(.NUM_CELLS(32), .SLEEP_FEATURE(1'b1)) dut_u (
        .clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awRdy), .s_axi_wdata(wData),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wRdy),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(1'b1),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arRdy), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(1'b1), .ioIn(ioIn),
        .oeRequest(oeReq), .sleepRequestPin(sleepPin), .ioOut(ioOut),
        .ioOe(oeOut), .keeperLevel(keep), .sleepActive(sleepAct));
    task automatic wrap_up();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [33:0] e, logic [33:0] s);
        compares++;
        if (e !== s) begin
            n_fail++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask
    // valid and payload stand until the rising edge that samples ready
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] e);
        wq.push_back(e);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awRdy) awValid <= 1'b0;
            if (wRdy) wValid <= 1'b0;
        end while ((awValid && !awRdy) || (wValid && !wRdy));
        wait (wq.size() == 0);
        @(posedge clk_sys);
    endtask
    task automatic rd(logic [7:0] a, logic [33:0] e, string nm);
        rq.push_back(e);
        rn.push_back(nm);
        arAddr <= a;
        arValid <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (!arRdy);
        arValid <= 1'b0;
        wait (rq.size() == 0);
        @(posedge clk_sys);
    endtask
    // answers taken at the rising edge that completes them
    always @(posedge clk_sys) begin
        if (rValid === 1'b1 && rq.size() > 0)
            chk(rn.pop_front(), rq.pop_front(), {rResp, rData});
        if (bValid === 1'b1 && wq.size() > 0)
            chk("bresp", {32'h0, wq.pop_front()}, {32'h0, bResp});
    end
    // main sequence: clear, run, sleep, wake, lock
    initial begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        @(negedge clk_sys);
        chk("ioOut", 34'h0, {2'h0, ioOut});
        @(posedge clk_sys);
        rd(ADDR_STATUS, {RESP_OKAY, 32'h0000_0011}, "status");
        repeat (POR_CYCLES + 10) @(posedge clk_sys);
        rd(ADDR_SLEW, {RESP_OKAY, SLEW_RESET}, "slew");
        pat = $random(seed);
        sig = $random(seed);
        wantIo <= pat;
        repeat (8) @(posedge clk_sys);
        rd(ADDR_CELL_STATE, {RESP_OKAY, pat}, "cells");
        $display("run test done");
        wantSleep <= 1'b1;
        repeat (8) @(posedge clk_sys);
        wantIo <= ~pat;
        repeat (8) @(negedge clk_sys);
        chk("asleep", 34'h1, {33'h0, sleepAct});
        chk("ioOut", {2'h0, pat}, {2'h0, ioOut});
        chk("keeper", {2'h0, pat}, {2'h0, keep});
        chk("ioOe", {2'h0, ~pat}, {2'h0, oeOut});
        @(posedge clk_sys);
        rd(ADDR_CELL_STATE, {RESP_OKAY, pat}, "frozen");
        wr(ADDR_PRELOAD_DATA, sig, RESP_SLVERR);
        wantSleep <= 1'b0;
        repeat (8) @(negedge clk_sys);
        chk("ioOut", {2'h0, ~pat}, {2'h0, ioOut});
        chk("ioOe", {2'h0, pat}, {2'h0, oeOut});
        $display("sleep test done");
        @(posedge clk_sys);
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        wantSleep <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rd(ADDR_CELL_STATE, {RESP_OKAY, ~pat ^ 32'h1}, "pinAsInput");
        rd(ADDR_STATUS, {RESP_OKAY, 32'h0000_0018}, "noSleep");
        wantSleep <= 1'b0;
        wr(ADDR_SLEW, 32'hFFFF_FFFF, RESP_OKAY);
        wr(ADDR_PRELOAD_MASK, 32'hFFFF_FFFF, RESP_OKAY);
        wr(ADDR_PRELOAD_DATA, sig, RESP_OKAY);
        wr(ADDR_SIG_BASE, sig, RESP_OKAY);
        wr(ADDR_CTRL, 32'h0000_0003, RESP_OKAY);
        rd(ADDR_CELL_STATE, {RESP_SLVERR, 32'h0}, "verify");
        wr(ADDR_PRELOAD_DATA, pat, RESP_SLVERR);
        rd(ADDR_SIG_BASE, {RESP_OKAY, sig}, "sig");
        rd(8'hFC, {RESP_SLVERR, 32'h0}, "unmapped");
        rd(ADDR_STATUS, {RESP_OKAY, 32'h0000_001C}, "locked");
        $display("lock test done");
        wrap_up();
    end
    // hang guard: the tests need about 1400 cycles
    initial begin
        #40000;
        n_fail++;
        wrap_up();
    end
endmodule // cpld_power_state_control_bench
